// File: verilog/swdc_regs.svh
/*
 constants of the single wire debug control block.
 assumes a 20 MHz core clock; times given in ns, counts derived.
*/
// Function
// - all commands, answers and data travel on the one debug pin.
// - pin picks the operating mode during reset, serial debug afterwards.
// - special single chip mode leaves reset with debug enabled and active.
// - emulation modes leave reset with debug enabled, not active.
// - emulation modes leave reset with clock source select set.
// - firmware commands are refused unless debug is enabled and active.
// - nine hardware commands, bus accesses taken in free cycles.
// - hardware commands run even when debug is not active.
// - fourteen firmware commands are handed to the firmware table.
// - in wait or stop only hardware reads, writes and ack on/off are served.
// - no low power entry while debug is active.
// - debug clocks stop only when all bus masters are stopped.
// - clock restart soft-resets: instruction, command and ack cleared.
// - secure mode blocks memory access and most debug operations.
// - secure special single chip with failed erase still reaches registers.
// - twelve register bytes then firmware rom fill the debug space.
// - while debug is active, one fixed rom location returns the family code.
// - sync request is answered with a timing pulse.
// - with ack on, each operation except ack off ends with a pin handshake pulse; reads send it before the data.
// - host reaches debug registers only via register read/write commands.
`ifndef SWDC_REGS_SVH
`define SWDC_REGS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define SWDC_CLK_NS 50
`define SWDC_SMP_NS 500
`define SWDC_SYNC_MIN_NS 6400
`define SWDC_SYNC_NS 6400
`define SWDC_ACK_NS 200
`define SWDC_BIT_NS 800
`define SWDC_ONE_NS 200
`define SWDC_ZERO_NS 650
`define SWDC_CYC_UP(t) (((t) + `SWDC_CLK_NS - 1) / `SWDC_CLK_NS)
`define SWDC_SMP_CYC 16'(`SWDC_CYC_UP(`SWDC_SMP_NS))
`define SWDC_SYNC_MIN_CYC 16'(`SWDC_CYC_UP(`SWDC_SYNC_MIN_NS))
`define SWDC_SYNC_CYC 16'(`SWDC_CYC_UP(`SWDC_SYNC_NS))
`define SWDC_ACK_CYC 16'(`SWDC_CYC_UP(`SWDC_ACK_NS))
`define SWDC_BIT_CYC 16'(`SWDC_CYC_UP(`SWDC_BIT_NS))
`define SWDC_ONE_CYC 16'(`SWDC_CYC_UP(`SWDC_ONE_NS))
`define SWDC_ZERO_CYC 16'(`SWDC_CYC_UP(`SWDC_ZERO_NS))
// ----------------------------------------
// commands
// ----------------------------------------
`define SWDC_C_ACK_ON 8'hD5
`define SWDC_C_ACK_OFF 8'hD6
`define SWDC_C_BKGND 8'h90
`define SWDC_C_RD_B 8'hE0
`define SWDC_C_WR_B 8'hC0
`define SWDC_C_RD_W 8'hE8
`define SWDC_C_WR_W 8'hC8
`define SWDC_C_RD_DBG 8'hE4
`define SWDC_C_WR_DBG 8'hC4
`define SWDC_FW_GRP 4'h4
`define SWDC_FW_CNT 4'hE
// ----------------------------------------
// debug space offsets, status bits
// ----------------------------------------
`define SWDC_STAT_OFS 8'h01
`define SWDC_REG_TOP 8'h0B
`define SWDC_ID_OFS 8'h0F
`define SWDC_B_EN 7
`define SWDC_B_ACT 6
`define SWDC_B_DEBUG_CLOCK_SOURCE_SELECT 2
`define SWDC_REG_SPACE 16'h0800
`endif

// File: verilog/swdc_pkg.sv
/*
 types of the single wire debug control block.
 assumes nothing beyond the constants header.
*/
package swdc_pkg;
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_BIT = 8'h02,
        ST_EXEC = 8'h04,
        ST_BUS = 8'h08,
        ST_TX = 8'h10,
        ST_ACK = 8'h20,
        ST_SYNC = 8'h40,
        ST_FW = 8'h80
    } swdc_state_t;
    typedef struct packed {
        logic req;
        logic we;
        logic word;
        logic [15:0] addr;
        logic [15:0] wdata;
    } swdc_bus_t;
    typedef struct packed {
        logic req;
        logic [7:0] cmd;
    } swdc_fw_t;
endpackage : swdc_pkg

// File: verilog/swdc_top.sv
/*
 control side of the single wire debug unit: pin receiver, command
 decode, status, low power and secure gating.
 assumes a system bus arbiter that grants in free cycles and firmware
 that runs handed-off commands.
*/
`timescale 1ns/1ns
`default_nettype none
`include "swdc_regs.svh"
module swdc_top #(
    parameter logic [7:0] FAMILY_ID = 8'h5A, // arbitrary value
    parameter bit EMUL_PRESENT = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_pin,
    output logic o_pin_out,
    output logic o_pin_oe,
    input wire logic i_sys_reset,
    input wire logic i_emul_strap,
    input wire logic i_cpu_lowpwr,
    input wire logic i_all_stop,
    input wire logic i_secure,
    input wire logic i_erase_fail,
    output swdc_pkg::swdc_bus_t o_bus,
    input wire logic i_bus_ack,
    input wire logic [15:0] i_bus_rdata,
    output swdc_pkg::swdc_fw_t o_fw,
    input wire logic i_fw_done,
    input wire logic i_fw_exit,
    output logic o_lp_inhibit,
    output logic o_dbg_clk_run,
    output logic o_enabled,
    output logic o_active,
    output logic o_debug_clock_source_select
);
    // ----------------------------------------
    // pin synchroniser, mode strap
    // ----------------------------------------
    logic pin_s1, pin_s2, pin_d;
    logic in_rst_d, mode_special, mode_emul, stop_d;
    logic rst_exit, restart, ssc;
    swdc_pkg::swdc_state_t state;
    logic [15:0] timer;
    logic [5:0] nbits;
    logic [39:0] sh;
    logic [7:0] cmd;
    logic [15:0] tx_sh;
    logic [4:0] tx_left;
    logic drive, ack_en, tx_pend;
    logic enabled, active, debug_clock_source_select;

    function automatic logic [5:0] arg_len(input logic [7:0] c);
        unique case (c)
            `SWDC_C_RD_B, `SWDC_C_RD_W, `SWDC_C_RD_DBG: arg_len = 6'd24;
            `SWDC_C_WR_B, `SWDC_C_WR_DBG: arg_len = 6'd32;
            `SWDC_C_WR_W: arg_len = 6'd40;
            default: arg_len = 6'd8;
        endcase
    endfunction : arg_len

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
            pin_d <= 1'b1;
        end else begin
            pin_s1 <= i_pin;
            pin_s2 <= pin_s1;
            pin_d <= pin_s2;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            in_rst_d <= 1'b1;
            mode_special <= 1'b0;
            mode_emul <= 1'b0;
            stop_d <= 1'b0;
        end else begin
            in_rst_d <= i_sys_reset;
            stop_d <= i_all_stop;
            if (i_sys_reset) begin
                mode_special <= ~pin_s2;
                mode_emul <= i_emul_strap & EMUL_PRESENT;
            end
        end
    end

    assign rst_exit = in_rst_d & ~i_sys_reset;
    assign restart = stop_d & ~i_all_stop;
    assign ssc = mode_special & ~mode_emul;

    // ----------------------------------------
    // command decode terms
    // ----------------------------------------
    logic exec, is_fw, is_rd, is_bus, word, bkgnd_ok, fw_ok, bus_ok;
    logic [4:0] dl;
    logic [15:0] addr, wdata;
    assign exec = (state == swdc_pkg::ST_EXEC);
    assign is_fw = (cmd[7:4] == `SWDC_FW_GRP) && (cmd[3:0] < `SWDC_FW_CNT);
    assign word = cmd[3];
    assign dl = word ? 5'd16 : 5'd8;
    assign is_rd = (cmd == `SWDC_C_RD_B) || (cmd == `SWDC_C_RD_W) || (cmd == `SWDC_C_RD_DBG);
    assign is_bus = (cmd == `SWDC_C_RD_B) || (cmd == `SWDC_C_RD_W)
        || (cmd == `SWDC_C_WR_B) || (cmd == `SWDC_C_WR_W);
    assign addr = is_rd ? sh[15:0] : sh[dl +: 16];
    assign wdata = word ? sh[15:0] : {8'h00, sh[7:0]};
    assign bkgnd_ok = enabled & ~i_cpu_lowpwr & ~i_secure;
    assign fw_ok = enabled & active & ~i_cpu_lowpwr & ~i_secure;
    assign bus_ok = ~i_secure | (ssc & i_erase_fail & (addr < `SWDC_REG_SPACE));

    function automatic logic [7:0] dbg_read(input logic [7:0] ofs);
        logic [7:0] r;
        r = 8'h00;
        if (ofs == `SWDC_STAT_OFS) begin
            r[`SWDC_B_EN] = enabled;
            r[`SWDC_B_ACT] = active;
            r[`SWDC_B_DEBUG_CLOCK_SOURCE_SELECT] = debug_clock_source_select;
        end else if (ofs > `SWDC_REG_TOP && active && ofs == `SWDC_ID_OFS) begin
            r = FAMILY_ID;
        end
        dbg_read = r;
    endfunction : dbg_read

    // ----------------------------------------
    // status: enable, active, clock select
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            enabled <= 1'b0;
            active <= 1'b0;
            debug_clock_source_select <= 1'b0;
        end else if (rst_exit) begin
            enabled <= ssc | mode_emul;
            active <= ssc;
            debug_clock_source_select <= mode_emul;
        end else begin
            if (exec && cmd == `SWDC_C_BKGND && bkgnd_ok)
                active <= 1'b1;
            else if (i_fw_exit)
                active <= 1'b0;
            if (exec && cmd == `SWDC_C_WR_DBG && !i_secure && addr[7:0] == `SWDC_STAT_OFS) begin
                enabled <= wdata[`SWDC_B_EN];
                debug_clock_source_select <= wdata[`SWDC_B_DEBUG_CLOCK_SOURCE_SELECT];
            end
        end
    end

    // ----------------------------------------
    // pin protocol state machine
    // ----------------------------------------
    swdc_pkg::swdc_state_t after_op;
    assign after_op = ack_en ? swdc_pkg::ST_ACK
        : (is_rd ? swdc_pkg::ST_TX : swdc_pkg::ST_IDLE);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= swdc_pkg::ST_IDLE;
            timer <= 16'h0000;
            nbits <= 6'h00;
            sh <= 40'h00_0000_0000;
            cmd <= 8'h00;
            tx_sh <= 16'h0000;
            tx_left <= 5'h00;
            tx_pend <= 1'b0;
            drive <= 1'b0;
            ack_en <= 1'b0;
            o_bus <= '0;
            o_fw <= '0;
        end else if (restart || i_sys_reset) begin
            state <= swdc_pkg::ST_IDLE;
            cmd <= 8'h00;
            nbits <= 6'h00;
            drive <= 1'b0;
            ack_en <= 1'b0;
            o_bus <= '0;
            o_fw <= '0;
        end else if (!i_all_stop) begin
            o_fw.req <= 1'b0;
            unique case (state)
                swdc_pkg::ST_IDLE: begin
                    timer <= 16'h0000;
                    if (pin_d && !pin_s2)
                        state <= swdc_pkg::ST_BIT;
                end
                swdc_pkg::ST_BIT: begin
                    timer <= timer + 16'h0001;
                    if (timer == `SWDC_SMP_CYC) begin
                        sh <= {sh[38:0], pin_s2};
                        nbits <= nbits + 6'h01;
                        if (nbits == 6'd7)
                            cmd <= {sh[6:0], pin_s2};
                    end
                    if (timer > `SWDC_SMP_CYC && pin_s2) begin
                        if (nbits >= 6'd8 && nbits == arg_len(cmd)) begin
                            state <= swdc_pkg::ST_EXEC;
                            nbits <= 6'h00;
                        end else begin
                            state <= swdc_pkg::ST_IDLE;
                        end
                    end else if (timer == `SWDC_SYNC_MIN_CYC) begin
                        state <= swdc_pkg::ST_SYNC;
                        nbits <= 6'h00;
                        timer <= 16'h0000;
                    end
                end
                swdc_pkg::ST_SYNC: begin
                    if (!drive) begin
                        drive <= pin_s2;
                        timer <= 16'h0000;
                    end else begin
                        timer <= timer + 16'h0001;
                        if (timer == `SWDC_SYNC_CYC - 16'h0001) begin
                            drive <= 1'b0;
                            state <= swdc_pkg::ST_IDLE;
                        end
                    end
                end
                swdc_pkg::ST_EXEC: begin
                    timer <= 16'h0000;
                    tx_left <= dl;
                    tx_pend <= is_rd;
                    state <= swdc_pkg::ST_IDLE;
                    if (is_bus && bus_ok) begin
                        o_bus <= {1'b1, ~is_rd, word, addr, wdata};
                        state <= swdc_pkg::ST_BUS;
                    end else if (is_bus) begin
                        tx_sh <= 16'h0000;
                        state <= after_op;
                    end else if (cmd == `SWDC_C_RD_DBG) begin
                        tx_sh <= {dbg_read(addr[7:0]), 8'h00};
                        state <= after_op;
                    end else if (cmd == `SWDC_C_WR_DBG) begin
                        state <= after_op;
                    end else if (cmd == `SWDC_C_ACK_ON) begin
                        ack_en <= 1'b1;
                        state <= swdc_pkg::ST_ACK;
                    end else if (cmd == `SWDC_C_ACK_OFF) begin
                        ack_en <= 1'b0;
                    end else if (cmd == `SWDC_C_BKGND && bkgnd_ok) begin
                        state <= after_op;
                    end else if (is_fw && fw_ok) begin
                        o_fw <= {1'b1, cmd};
                        state <= swdc_pkg::ST_FW;
                    end
                end
                swdc_pkg::ST_BUS: begin
                    if (i_bus_ack) begin
                        o_bus.req <= 1'b0;
                        tx_sh <= word ? i_bus_rdata : {i_bus_rdata[7:0], 8'h00};
                        state <= after_op;
                    end
                end
                swdc_pkg::ST_FW: begin
                    if (i_fw_done)
                        state <= ack_en ? swdc_pkg::ST_ACK : swdc_pkg::ST_IDLE;
                end
                swdc_pkg::ST_ACK: begin
                    timer <= timer + 16'h0001;
                    drive <= (timer < `SWDC_ACK_CYC);
                    if (timer == `SWDC_ACK_CYC) begin
                        timer <= 16'h0000;
                        tx_pend <= 1'b0;
                        state <= tx_pend ? swdc_pkg::ST_TX : swdc_pkg::ST_IDLE;
                    end
                end
                swdc_pkg::ST_TX: begin
                    timer <= timer + 16'h0001;
                    drive <= timer < (tx_sh[15] ? `SWDC_ONE_CYC : `SWDC_ZERO_CYC);
                    if (timer == `SWDC_BIT_CYC - 16'h0001) begin
                        timer <= 16'h0000;
                        tx_sh <= {tx_sh[14:0], 1'b0};
                        tx_left <= tx_left - 5'h01;
                        if (tx_left == 5'h01) begin
                            tx_pend <= 1'b0;
                            state <= swdc_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    assign o_pin_out = 1'b0;
    assign o_pin_oe = drive;
    assign o_lp_inhibit = active;
    assign o_dbg_clk_run = ~i_all_stop;
    assign o_enabled = enabled;
    assign o_active = active;
    assign o_debug_clock_source_select = debug_clock_source_select;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence ack_pulse;
        o_pin_oe [*4] ##1 !o_pin_oe;
    endsequence
    sequence exit_ssc;
        rst_exit && ssc;
    endsequence

    ssc_exit_state_a: assert property (exit_ssc |=> enabled && active)
        else $error("special single chip exit not enabled and active");
    emul_exit_state_a: assert property (rst_exit && mode_emul |=> enabled && !active)
        else $error("emulation exit state wrong");
    emul_debug_clock_source_select_a: assert property (rst_exit && mode_emul |=> debug_clock_source_select)
        else $error("clock select not set after emulation exit");
    reset_pin_quiet_a: assert property (i_sys_reset |=> !o_pin_oe)
        else $error("debug pin driven during reset");
    fw_gate_a: assert property ($rose(o_fw.req) |-> enabled && !$past(i_cpu_lowpwr))
        else $error("firmware command passed while refused");
    lowpwr_fw_a: assert property (exec && is_fw && i_cpu_lowpwr && !i_all_stop
        |=> state == swdc_pkg::ST_IDLE && !o_fw.req)
        else $error("firmware command served in low power");
    bkgnd_inhibit_a: assert property (exec && cmd == `SWDC_C_BKGND && bkgnd_ok
        && !i_all_stop && !i_fw_exit |=> o_lp_inhibit)
        else $error("low power not inhibited after entry");
    soft_reset_a: assert property (restart |=> state == swdc_pkg::ST_IDLE && !ack_en
        && !o_pin_oe && cmd == 8'h00)
        else $error("soft reset incomplete");
    ack_len_a: assert property ($rose(state == swdc_pkg::ST_ACK) |=> ack_pulse)
        else $error("ack pulse length wrong");
    secure_bus_a: assert property ($rose(o_bus.req) && i_secure |-> ssc && i_erase_fail)
        else $error("bus access while secure");
    id_read_a: assert property (exec && cmd == `SWDC_C_RD_DBG && addr[7:0] == `SWDC_ID_OFS
        && active && !i_all_stop && !restart |=> tx_sh[15:8] == FAMILY_ID)
        else $error("family code read wrong");
    hw_inactive_a: assert property (exec && cmd == `SWDC_C_WR_B && !active && !i_secure
        && !i_all_stop && !restart && !i_sys_reset |=> o_bus.req && o_bus.we)
        else $error("hardware write not issued while inactive");
endmodule : swdc_top
`default_nettype wire

// File: bench/swdc_host_model.sv
/*
 host model on the single debug pin: bit sender and sync request.
 assumes a pull-up on the pin; the device pulls low via i_dev_oe.
*/
`timescale 1ns/1ns
`default_nettype none
module swdc_host_model (
    input wire logic i_clk,
    input wire logic i_dev_oe,
    output var logic o_pin
);
    logic host_oe = 1'b0;
    // one open drain wire carries everything
    assign o_pin = ~(host_oe | i_dev_oe);
    task automatic hold_low(input logic low);
        @(posedge i_clk);
        #5 host_oe = low;
    endtask : hold_low
    // msb first, 16 cycle cells: short low is 1, long low is 0
    task automatic send8(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            hold_low(1'b1);
            repeat (b[i] ? 4 : 13) @(posedge i_clk);
            #5 host_oe = 1'b0;
            repeat (b[i] ? 11 : 2) @(posedge i_clk);
        end
    endtask : send8
    // long low; the device answers with a timing pulse
    task automatic sync_req();
        hold_low(1'b1);
        repeat (140) @(posedge i_clk);
        #5 host_oe = 1'b0;
    endtask : sync_req
endmodule : swdc_host_model
`default_nettype wire

// File: bench/tb.sv
/*
 self-checking bench of the debug control block.
 assumes swdc_host_model on the pin and a bus partner modelled here.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_pin, i_sys_reset = 1'b0, i_emul_strap = 1'b0;
    logic i_cpu_lowpwr = 1'b0, i_all_stop = 1'b0, i_secure = 1'b0, i_erase_fail = 1'b0;
    logic i_bus_ack = 1'b0, i_fw_done = 1'b0, i_fw_exit = 1'b0;
    logic [15:0] i_bus_rdata = 16'h0000, exp_rd = 16'h0000, a, d;
    logic o_pin_out, o_pin_oe, o_lp_inhibit, o_dbg_clk_run, o_enabled, o_active, o_debug_clock_source_select;
    swdc_pkg::swdc_bus_t o_bus, last_bus;
    swdc_pkg::swdc_fw_t o_fw;
    logic [7:0] last_fw;
    int num_errors = 0, n_checks = 0, n_bus = 0, n_fw = 0, run = 0, n;
    int pq[$];
    localparam logic [7:0] FAM = 8'hA7; // arbitrary value
    always #25 i_clk = ~i_clk;
    swdc_top #(.FAMILY_ID(FAM)) dut_u (.i_clk, .i_rst_n, .i_pin, .o_pin_out, .o_pin_oe,
        .i_sys_reset, .i_emul_strap, .i_cpu_lowpwr, .i_all_stop, .i_secure, .i_erase_fail,
        .o_bus, .i_bus_ack, .i_bus_rdata, .o_fw, .i_fw_done, .i_fw_exit, .o_lp_inhibit,
        .o_dbg_clk_run, .o_enabled, .o_active, .o_debug_clock_source_select);
    swdc_host_model host_u (.i_clk(i_clk), .i_dev_oe(o_pin_oe), .o_pin(i_pin));
    // ----------------------------------------
    // monitors and bus partner
    // ----------------------------------------
    always @(posedge i_clk) begin
        if (o_pin_oe === 1'b1) begin
            run++;
        end else if (run != 0) begin
            pq.push_back(run);
            run = 0;
        end
        if (o_fw.req === 1'b1) begin
            n_fw++;
            last_fw = o_fw.cmd;
        end
    end
    always begin
        @(posedge i_clk);
        if (o_bus.req === 1'b1) begin
            last_bus = o_bus;
            n_bus++;
            repeat ($urandom_range(2, 0)) @(posedge i_clk);
            #5 i_bus_ack = 1'b1;
            exp_rd = 16'($urandom);
            i_bus_rdata = exp_rd;
            @(posedge i_clk);
            #5 i_bus_ack = 1'b0;
            i_bus_rdata = ~exp_rd;
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic tick(input int k);
        repeat (k) @(posedge i_clk);
        #5;
    endtask : tick
    task automatic wait_q(input int k);
        int t;
        t = 0;
        while (pq.size() < k && t < 4000) begin
            @(posedge i_clk);
            t++;
        end
        if (t == 4000) begin
            num_errors++;
            $display("[FAIL] pin pulses expected %0d seen %0d", k, pq.size());
            report_and_stop();
        end
    endtask : wait_q
    // byte reads carry the low byte, word reads all sixteen bits
    function automatic logic [15:0] rd_exp(input int k);
        rd_exp = (k == 8) ? {8'h00, exp_rd[7:0]} : exp_rd;
    endfunction : rd_exp
    task automatic expect_rx(input logic [15:0] v, input int k, input bit ack, input bit bus);
        logic [15:0] got;
        got = 16'h0000;
        wait_q(k + int'(ack));
        if (bus)
            v = rd_exp(k);
        if (ack)
            check("ack pulse", pq.pop_front(), 4);
        for (int i = k - 1; i >= 0; i--)
            got[i] = (pq.pop_front() == 4);
        check("rx data", got, v);
        // last bit cell must end before the next command
        tick(16);
    endtask : expect_rx
    task automatic bus_cmd(input logic [7:0] c, input logic [15:0] ad);
        pq.delete();
        host_u.send8(c);
        host_u.send8(ad[15:8]);
        host_u.send8(ad[7:0]);
    endtask : bus_cmd
    task automatic mode(input logic lo, input logic emu, input logic [2:0] st);
        tick(1);
        i_sys_reset = 1'b1;
        i_emul_strap = emu;
        host_u.host_oe = lo;
        tick(4);
        i_sys_reset = 1'b0;
        host_u.host_oe = 1'b0;
        tick(4);
        check("mode status", {o_enabled, o_active, o_debug_clock_source_select}, st);
        pq.delete();
    endtask : mode
    task automatic fw_try(input logic [7:0] c, input int exp_n);
        n = n_fw;
        host_u.send8(c);
        tick(20);
        check("fw requests", n_fw - n, exp_n);
    endtask : fw_try
    task automatic rd_bus(input logic [15:0] ad, input int exp_n, input bit ack);
        n = n_bus;
        bus_cmd(8'hE0, ad);
        expect_rx(16'h0000, 8, ack, exp_n != 0);
        check("bus requests", n_bus - n, exp_n);
    endtask : rd_bus
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h2284));
        tick(16);
        i_rst_n = 1'b1;
        mode(1'b1, 1'b0, 3'b110);
        check("lp inhibit", o_lp_inhibit, 1'b1);
        bus_cmd(8'hE4, 16'h000F);
        expect_rx({8'h00, FAM}, 8, 1'b0, 1'b0);
        bus_cmd(8'hE4, 16'h0001);
        expect_rx(16'h00C0, 8, 1'b0, 1'b0);
        for (int c = 0; c < 14; c++) begin
            fw_try(8'h40 + 8'(c), 1);
            check("fw cmd", last_fw, 8'h40 + 8'(c));
            i_fw_done = 1'b1;
            tick(1);
            i_fw_done = 1'b0;
        end
        pq.delete();
        host_u.sync_req();
        wait_q(1);
        check("sync pulse", pq.pop_front(), 128);
        host_u.send8(8'hD5);
        wait_q(1);
        check("ack on", pq.pop_front(), 4);
        repeat (4) begin
            rd_bus(16'($urandom_range(16'h07FF, 0)), 1, 1'b1);
            check("bus kind", {last_bus.we, last_bus.word}, 2'b00);
        end
        a = 16'($urandom);
        d = 16'($urandom);
        bus_cmd(8'hC8, a);
        host_u.send8(d[15:8]);
        host_u.send8(d[7:0]);
        wait_q(1);
        check("write ack", pq.pop_front(), 4);
        check("bus write", {last_bus.we, last_bus.word, last_bus.addr, last_bus.wdata},
            {2'b11, a, d});
        bus_cmd(8'hE8, a);
        expect_rx(16'h0000, 16, 1'b1, 1'b1);
        host_u.send8(8'hE0);
        tick(1);
        i_all_stop = 1'b1;
        tick(8);
        check("clock stop", o_dbg_clk_run, 1'b0);
        i_all_stop = 1'b0;
        tick(2);
        check("clock run", {o_dbg_clk_run, o_pin_oe, o_pin_out}, 3'b100);
        rd_bus(16'h0123, 1, 1'b0);
        i_fw_exit = 1'b1;
        tick(1);
        i_fw_exit = 1'b0;
        tick(2);
        check("exit active", {o_active, o_lp_inhibit}, 2'b00);
        mode(1'b0, 1'b1, 3'b101);
        i_cpu_lowpwr = 1'b1;
        host_u.send8(8'h90);
        fw_try(8'h40, 0);
        check("bkgnd gated", o_active, 1'b0);
        rd_bus(16'h0010, 1, 1'b0);
        i_cpu_lowpwr = 1'b0;
        host_u.send8(8'h90);
        tick(30);
        check("bkgnd", {o_active, o_lp_inhibit}, 2'b11);
        mode(1'b0, 1'b0, 3'b000);
        fw_try(8'h41, 0);
        rd_bus(16'($urandom_range(16'h07FF, 0)), 1, 1'b0);
        n = n_bus;
        bus_cmd(8'hC0, a);
        host_u.send8(d[7:0]);
        tick(20);
        check("byte write", {8'(n_bus - n), last_bus.we, last_bus.word, last_bus.addr,
            last_bus.wdata}, {8'h01, 2'b10, a, 8'h00, d[7:0]});
        bus_cmd(8'hC4, 16'h0001);
        host_u.send8(8'h84);
        tick(20);
        check("status write", {o_enabled, o_debug_clock_source_select}, 2'b11);
        i_secure = 1'b1;
        rd_bus(16'h0200, 0, 1'b0);
        mode(1'b1, 1'b0, 3'b110);
        i_erase_fail = 1'b1;
        rd_bus(16'h0100, 1, 1'b0);
        host_u.send8(8'hD5);
        wait_q(1);
        check("ack on", pq.pop_front(), 4);
        rd_bus(16'h0100, 1, 1'b1);
        host_u.send8(8'hD6);
        rd_bus(16'h0100, 1, 1'b0);
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
